// >>> iep_pkg.sv
// constants and types for the interrupt entry and low-power unit
package iep_pkg;
	// ****************************************************************
	// apb register map
	// ****************************************************************
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_SRC    = 8'h08;
	localparam logic [7:0] ADDR_ENABLE = 8'h0c;
	localparam logic [7:0] ADDR_CLEAR  = 8'h10;
	// ctrl fields
	localparam int CTRL_DLY   = 0;
	localparam int CTRL_WDDIS = 1;
	localparam int CTRL_PSEL  = 4;
	localparam logic [3:0] PSEL_RST = 4'h6;
	// ****************************************************************
	// sources and vectors
	// ****************************************************************
	localparam int NSRC = 16;
	localparam logic [3:0] SRC_IRQ = 4'h6;
	localparam logic [15:0] VEC_NONMASKABLE_REQUEST_PIN = 16'hfff4;
	localparam logic [15:0] VEC_SWI  = 16'hfff6;
	localparam logic [15:0] VEC_ILL  = 16'hfff8;
	// stack offsets of the nine stacked bytes
	localparam logic [15:0] STK_LAST = 16'h0008;
	localparam logic [3:0]  NSTK     = 4'h9;
	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_MHZ = 100;
	localparam int STAB_US = 40;
	localparam int STAB_CYC = STAB_US * CLK_MHZ;
	// ccr bit positions
	localparam int CCR_S = 7;
	localparam int CCR_X = 6;
	localparam int CCR_I = 4;
	typedef enum logic [2:0] {
		ST_RUN, ST_PUSH, ST_VEC, ST_POP, ST_WAIT, ST_STOP, ST_DELAY
	} iep_state_e;
endpackage

// >>> iep_stack_mem.sv
// stack memory seen on the unit's byte bus
`timescale 1ns/100ps
module iep_stack_mem (
	input  wire logic        i_clk,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [15:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	output logic      [7:0]  o_rdata
);
	logic [7:0] mem [65536];
	logic [7:0] last;
	always_ff @(posedge i_clk) begin
		if (i_wr)
			mem[i_addr] <= i_wdata;
		if (i_rd)
			last <= o_rdata;
	end
	// idle bus shows the inverse of the last byte
	assign o_rdata = i_rd ? mem[i_addr] : ~last;
endmodule // iep_stack_mem

// >>> iep_unit.sv
// exception entry, return, wait and stop sequencing unit
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
// Functional notes
// - recognise when local enable and mask allow
// - push pc, y, x, a, b, flags downward
// - set masks after flags, then fetch vector
// - return pops in reverse, restoring masks
// - reset sets global and nonmaskable masks
// - nonmaskable gate clearable only, never set by software
// - nonmaskable pin beats all maskable sources
// - maskable entry sets only global mask
// - illegal opcode traps, stacks opcode address
// - software trap ignores masks, sets global
// - maskable pin is low-level sensitive
// - flag holds request until cleared
// - wait stacks then halts until interrupt
// - wait reads repeat at flags address
// - timer stops only if masked, watchdog off
// - stop enters only when halt permit 0
// - stop exits on pins or pending edge
// - stop freezes state, resumes as before
// - maskable pin wakes only if unmasked
// - nonmaskable pin always wakes from stop
// - delay enable set by reset, clearable
// - delay always after power-on reset
// - three nonmaskable sources exactly
// - priority select writable only while masked
module iep_unit #(
	parameter int STAB_CYCLES = iep_pkg::STAB_CYC
) (
	input  wire logic        I_SYS_CLK,
	input  wire logic        I_SYS_RST,
	input  wire logic        I_POR,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic             PREADY,
	output logic [31:0]      PRDATA,
	output logic             PSLVERR,
	input  wire logic        i_boundary,
	input  wire logic        i_op_swi,
	input  wire logic        i_op_wai,
	input  wire logic        i_op_stop,
	input  wire logic        i_op_rti,
	input  wire logic        i_op_tap,
	input  wire logic        i_op_illegal,
	input  wire logic [15:0] i_op_addr,
	input  wire logic [15:0] i_next_pc,
	input  wire logic [7:0]  i_acc_a,
	input  wire logic [7:0]  i_acc_b,
	input  wire logic [15:0] i_ix,
	input  wire logic [15:0] i_iy,
	input  wire logic [15:0] i_sp,
	input  wire logic [7:0]  i_ccr,
	input  wire logic [7:0]  i_pop_data,
	input  wire logic        i_irq_n,
	input  wire logic        i_nonmaskable_request_pin_n,
	input  wire logic [15:0] i_event,
	output logic             o_cpu_hold,
	output logic             o_bus_rd,
	output logic             o_bus_wr,
	output logic [15:0]      o_bus_addr,
	output logic [7:0]       o_bus_wdata,
	output logic [15:0]      o_jump_pc,
	output logic             o_jump,
	output logic [7:0]       o_ccr,
	output logic             o_ccr_load,
	output logic             o_timer_stop,
	output logic             o_clk_stop
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		iep_pkg::iep_state_e st;
		logic [3:0]  idx;
		logic [15:0] sp;
		logic [71:0] frame;
		logic [15:0] vec;
		logic        nmi;
		logic        is_wait;
		logic        dly;
		logic        wddis;
		logic [3:0]  psel;
		logic [15:0] flag;
		logic [15:0] en;
		logic        por_dly;
		logic [31:0] cnt;
		logic        xmask;
		logic        imask;
		logic        xedge;
		logic        xprev;
		logic        ready;
		logic [31:0] rdata;
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic [15:0] jpc;
		logic        jump;
		logic [7:0]  condition_code_register;
		logic        ccr_ld;
		logic        tstop;
		logic        cstop;
	} iep_reg_s;

	iep_reg_s r;
	iep_reg_s next_r;

	// highest pending maskable source index, promoted one first
	function automatic logic [4:0] pick(input logic [15:0] req,
		input logic [3:0] pro);
		logic [4:0] res;
		res = 5'h10;
		for (int k = 0; k < iep_pkg::NSRC; k++) begin
			if (req[k]) begin
				res = 5'(k);
			end
		end
		if (req[pro]) begin
			res = {1'b0, pro};
		end
		return res;
	endfunction

	// vector of a maskable source index: index k maps to ffd6 + 2k
	function automatic logic [15:0] vec_of(input logic [3:0] k);
		return 16'hffd6 + {11'h000, k, 1'b0};
	endfunction

	logic [15:0] mreq;
	logic [4:0]  win;
	logic        nonmaskable_request_pin_req;
	logic        bus_wr;

	always_comb begin
		mreq = (r.flag & r.en);
		mreq[iep_pkg::SRC_IRQ] = ~i_irq_n;
		win = pick(mreq, r.psel);
		nonmaskable_request_pin_req = ~i_nonmaskable_request_pin_n & ~r.xmask;
		// write lands at the edge where the master sees ready
		bus_wr = PSEL & PENABLE & PWRITE & r.ready;
	end

	always_comb begin
		next_r = r;
		next_r.ready = 1'b0;
		next_r.jump = 1'b0;
		next_r.ccr_ld = 1'b0;
		next_r.wr = 1'b0;
		next_r.rd = 1'b0;
		next_r.xprev = i_nonmaskable_request_pin_n;
		next_r.flag = r.flag | i_event;
		// ************************************************************
		// apb slave
		// ************************************************************
		if (PSEL & PENABLE & ~r.ready) begin
			next_r.ready = 1'b1;
			next_r.rdata = 32'h0;
			unique case (PADDR)
				iep_pkg::ADDR_CTRL: next_r.rdata = {24'h0, r.psel, 2'h0,
					r.wddis, r.dly};
				iep_pkg::ADDR_STATUS: next_r.rdata = {24'h0,
					5'(r.st), r.xmask, r.imask, r.is_wait};
				iep_pkg::ADDR_SRC: next_r.rdata = {16'h0, r.flag};
				iep_pkg::ADDR_ENABLE: next_r.rdata = {16'h0, r.en};
				default: next_r.rdata = 32'h0;
			endcase
		end
		if (bus_wr) begin
			unique case (PADDR)
				iep_pkg::ADDR_CTRL: begin
					next_r.dly = PWDATA[iep_pkg::CTRL_DLY];
					next_r.wddis = PWDATA[iep_pkg::CTRL_WDDIS];
					if (r.imask) begin
						next_r.psel = PWDATA[iep_pkg::CTRL_PSEL +: 4];
					end
				end
				iep_pkg::ADDR_ENABLE: next_r.en = PWDATA[15:0];
				iep_pkg::ADDR_CLEAR: begin
					// event in same cycle wins over clear
					next_r.flag = (r.flag & ~PWDATA[15:0]) | i_event;
				end
				default: ;
			endcase
		end
		// ************************************************************
		// sequencer
		// ************************************************************
		unique case (r.st)
			iep_pkg::ST_RUN: begin
				if (i_op_tap) begin
					next_r.imask = i_ccr[iep_pkg::CCR_I];
					next_r.xmask = r.xmask & i_ccr[iep_pkg::CCR_X];
				end
				if (i_boundary) begin
					next_r.sp = i_sp;
					next_r.idx = 4'h0;
					next_r.nmi = 1'b0;
					next_r.is_wait = 1'b0;
					next_r.frame = {i_next_pc[7:0], i_next_pc[15:8], i_iy[7:0],
						i_iy[15:8], i_ix[7:0], i_ix[15:8], i_acc_a, i_acc_b,
						i_ccr};
					if (i_op_illegal) begin
						next_r.frame[71:56] = {i_op_addr[7:0], i_op_addr[15:8]};
						next_r.vec = iep_pkg::VEC_ILL;
						next_r.st = iep_pkg::ST_PUSH;
					end else if (i_op_swi) begin
						next_r.vec = iep_pkg::VEC_SWI;
						next_r.st = iep_pkg::ST_PUSH;
					end else if (i_op_rti) begin
						next_r.st = iep_pkg::ST_POP;
					end else if (i_op_stop) begin
						if (!i_ccr[iep_pkg::CCR_S]) begin
							next_r.st = iep_pkg::ST_STOP;
							next_r.cstop = 1'b1;
						end
					end else if (i_op_wai) begin
						next_r.is_wait = 1'b1;
						next_r.st = iep_pkg::ST_PUSH;
					end else if (nonmaskable_request_pin_req) begin
						next_r.nmi = 1'b1;
						next_r.vec = iep_pkg::VEC_NONMASKABLE_REQUEST_PIN;
						next_r.st = iep_pkg::ST_PUSH;
					end else if (!r.imask && !win[4]) begin
						next_r.vec = vec_of(win[3:0]);
						next_r.st = iep_pkg::ST_PUSH;
					end
				end
			end
			iep_pkg::ST_PUSH: begin
				next_r.wr = 1'b1;
				next_r.addr = r.sp - {12'h000, r.idx};
				next_r.wdata = r.frame[71 - 8 * r.idx -: 8];
				next_r.idx = r.idx + 4'h1;
				if (r.idx == iep_pkg::NSTK - 4'h1) begin
					next_r.st = r.is_wait ? iep_pkg::ST_WAIT : iep_pkg::ST_VEC;
				end
			end
			iep_pkg::ST_VEC: begin
				next_r.imask = 1'b1;
				if (r.nmi) begin
					next_r.xmask = 1'b1;
				end
				next_r.condition_code_register = {r.frame[7], r.frame[6] | r.nmi, r.frame[5], 1'b1,
					r.frame[3:0]};
				next_r.ccr_ld = 1'b1;
				next_r.jpc = r.vec;
				next_r.jump = 1'b1;
				next_r.tstop = 1'b0;
				next_r.st = iep_pkg::ST_RUN;
			end
			iep_pkg::ST_WAIT: begin
				next_r.rd = 1'b1;
				next_r.addr = r.sp - iep_pkg::STK_LAST;
				next_r.tstop = r.imask & r.wddis;
				if (nonmaskable_request_pin_req) begin
					next_r.nmi = 1'b1;
					next_r.vec = iep_pkg::VEC_NONMASKABLE_REQUEST_PIN;
					next_r.st = iep_pkg::ST_VEC;
				end else if (!r.imask && !win[4]) begin
					next_r.vec = vec_of(win[3:0]);
					next_r.st = iep_pkg::ST_VEC;
				end
			end
			iep_pkg::ST_STOP: begin
				// state frozen; only wake logic looks at pins
				if (!i_nonmaskable_request_pin_n) begin
					next_r.st = iep_pkg::ST_DELAY;
				end else if (!r.imask && !win[4]) begin
					next_r.st = iep_pkg::ST_DELAY;
				end
				next_r.cnt = r.dly ? 32'(STAB_CYCLES) : 32'h0;
			end
			iep_pkg::ST_DELAY: begin
				if (r.cnt != 32'h0) begin
					next_r.cnt = r.cnt - 32'h1;
				end else begin
					next_r.cstop = 1'b0;
					next_r.st = iep_pkg::ST_RUN;
				end
			end
			iep_pkg::ST_POP: begin
				// read data returns in the same cycle as its strobe
				next_r.rd = (r.idx != iep_pkg::NSTK);
				next_r.addr = r.sp + {12'h000, r.idx} + 16'h1;
				next_r.idx = r.idx + 4'h1;
				if (r.idx == 4'h1) begin
					next_r.condition_code_register = i_pop_data;
				end
				if (r.idx == iep_pkg::NSTK - 4'h1) begin
					next_r.jpc[15:8] = i_pop_data;
				end
				if (r.idx == iep_pkg::NSTK) begin
					next_r.jpc[7:0] = i_pop_data;
					next_r.jump = 1'b1;
					next_r.imask = r.condition_code_register[iep_pkg::CCR_I];
					next_r.xmask = r.xmask & r.condition_code_register[iep_pkg::CCR_X];
					next_r.ccr_ld = 1'b1;
					next_r.st = iep_pkg::ST_RUN;
				end
			end
			default: next_r.st = iep_pkg::ST_RUN;
		endcase
		if (r.por_dly) begin
			// power-on always waits, warm reset does not
			next_r.cnt = r.cnt - 32'h1;
			if (r.cnt == 32'h1) begin
				next_r.por_dly = 1'b0;
			end
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			r <= '0;
			r.st <= iep_pkg::ST_RUN;
			r.imask <= 1'b1;
			r.xmask <= 1'b1;
			r.dly <= 1'b1;
			r.psel <= iep_pkg::PSEL_RST;
			r.xprev <= 1'b1;
			if (I_POR) begin
				r.por_dly <= 1'b1;
				r.cnt <= 32'(STAB_CYCLES);
			end
		end else if (I_POR & ~r.por_dly) begin
			r.por_dly <= 1'b1;
			r.cnt <= 32'(STAB_CYCLES);
		end else begin
			r <= next_r;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	always_comb begin
		PREADY = r.ready;
		PRDATA = r.rdata;
		PSLVERR = 1'b0;
		o_cpu_hold = r.por_dly;
		o_bus_rd = r.rd;
		o_bus_wr = r.wr;
		o_bus_addr = r.addr;
		o_bus_wdata = r.wdata;
		o_jump_pc = r.jpc;
		o_jump = r.jump;
		o_ccr = r.condition_code_register;
		o_ccr_load = r.ccr_ld;
		o_timer_stop = r.tstop;
		o_clk_stop = r.cstop;
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	property p_reset_masks;
		@(posedge I_SYS_CLK) $past(I_SYS_RST) |-> r.imask && r.xmask;
	endproperty
	a_reset_masks: assert property (p_reset_masks)
		else $error("masks not set after reset");
	property p_xmask_sticky;
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		!r.xmask && r.st != iep_pkg::ST_VEC |=> !r.xmask;
	endproperty
	a_xmask_sticky: assert property (p_xmask_sticky)
		else $error("nonmaskable gate set by software");
	property p_nmi_vec;
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		r.st == iep_pkg::ST_VEC && r.nmi |=> r.xmask && r.imask;
	endproperty
	a_nmi_vec: assert property (p_nmi_vec)
		else $error("nonmaskable entry did not set both masks");
	property p_push_len;
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		$rose(r.st == iep_pkg::ST_PUSH) |=> r.wr [*8] ##1 r.wr ##1 !r.wr;
	endproperty
	a_push_len: assert property (p_push_len)
		else $error("push length wrong");
	property p_wait_addr;
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		r.st == iep_pkg::ST_WAIT |=> o_bus_addr == r.sp - 16'h0008;
	endproperty
	a_wait_addr: assert property (p_wait_addr)
		else $error("wait read address wrong");
	property p_stop_permit;
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		r.st == iep_pkg::ST_RUN && i_boundary && i_op_stop
		&& i_ccr[iep_pkg::CCR_S] && !i_op_illegal && !i_op_swi
		|=> r.st != iep_pkg::ST_STOP;
	endproperty
	a_stop_permit: assert property (p_stop_permit)
		else $error("stop entered while not permitted");
	property p_tstop;
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		r.tstop |-> r.imask && r.wddis;
	endproperty
	a_tstop: assert property (p_tstop)
		else $error("timer stopped without permission");
	property p_psel_lock;
		@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
		!r.imask |=> r.psel == $past(r.psel);
	endproperty
	a_psel_lock: assert property (p_psel_lock)
		else $error("priority select written while unmasked");
endmodule // iep_unit

// >>> interrupt_entry_and_low_power_tb_top.sv
// self-checking bench for the exception and low-power unit
`timescale 1ns/100ps
module interrupt_entry_and_low_power_tb_top;
	localparam int STAB = 4;
	logic        clk, rst, por, psel, pen, pwr, pready, pslverr;
	logic        bnd, software_trap_instruction, wait_instruction, stp, rti, tap, ill, irq_n, nonmaskable_request_pin_n;
	logic        hold, brd, bwr, jmp, cld, tst, cst;
	logic [7:0]  paddr, a, b, condition_code_register, pop, bwd, occr;
	logic [15:0] opa, npc, ix, iy, sp, ev, baddr, jpc;
	logic [31:0] pwd, prd, rd;
	int          n_fail = 0;
	int          checks = 0;
	int          k, n;

	iep_unit #(.STAB_CYCLES(STAB)) i_dut (
		.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_POR(por), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd),
		.PREADY(pready), .PRDATA(prd), .PSLVERR(pslverr),
		.i_boundary(bnd), .i_op_swi(software_trap_instruction), .i_op_wai(wait_instruction),
		.i_op_stop(stp), .i_op_rti(rti), .i_op_tap(tap),
		.i_op_illegal(ill), .i_op_addr(opa), .i_next_pc(npc),
		.i_acc_a(a), .i_acc_b(b), .i_ix(ix), .i_iy(iy), .i_sp(sp),
		.i_ccr(condition_code_register), .i_pop_data(pop), .i_irq_n(irq_n),
		.i_nonmaskable_request_pin_n(nonmaskable_request_pin_n), .i_event(ev), .o_cpu_hold(hold),
		.o_bus_rd(brd), .o_bus_wr(bwr), .o_bus_addr(baddr),
		.o_bus_wdata(bwd), .o_jump_pc(jpc), .o_jump(jmp),
		.o_ccr(occr), .o_ccr_load(cld), .o_timer_stop(tst),
		.o_clk_stop(cst));
	iep_stack_mem i_mem (.i_clk(clk), .i_wr(bwr), .i_rd(brd),
		.i_addr(baddr), .i_wdata(bwd), .o_rdata(pop));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		if (n_fail == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic tmo(input int c);
		if (c >= 40) begin
			n_fail++;
			stop_test();
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] wd);
		@(posedge clk) {psel, pen, pwr, paddr, pwd} <= {2'b10, w, ad, wd};
		@(posedge clk) pen <= 1'b1;
		for (k = 0; k < 40 && pready !== 1'b1; k++)
			@(posedge clk);
		tmo(k);
		rd = prd;
		{psel, pen} <= 2'b00;
	endtask
	// expected stack image kept in a queue, compared byte by byte
	task automatic exc(input logic [2:0] op, input logic [7:0] c,
		input logic [15:0] vec, input logic [7:0] nc, input logic [15:0] ret);
		logic [7:0] q[$];
		q = '{ret[7:0], ret[15:8], iy[7:0], iy[15:8], ix[7:0], ix[15:8],
			a, b, c};
		// software sets the masks from c before the boundary
		@(posedge clk) {tap, condition_code_register} <= {1'b1, c};
		@(posedge clk) {tap, bnd, software_trap_instruction, ill, wait_instruction} <= {1'b0, 1'b1, op};
		n = 0;
		for (k = 0; k < 40; k++) begin
			@(posedge clk) {bnd, software_trap_instruction, ill, wait_instruction} <= 4'h0;
			if (bwr === 1'b1) begin
				chk(baddr, sp - n);
				chk(bwd, q[n]);
				n++;
			end
			if (jmp === 1'b1 || (op[0] && brd === 1'b1))
				break;
		end
		tmo(k);
		chk(n, 9);
		if (!op[0])
			chk({cld, occr, jpc}, {1'b1, nc, vec});
	endtask
	task automatic quiet(input logic [7:0] c, input logic st);
		@(posedge clk) {tap, condition_code_register} <= {1'b1, c};
		@(posedge clk) {tap, bnd, stp} <= {1'b0, 1'b1, st};
		n = 0;
		repeat (20) begin
			@(posedge clk) {bnd, stp} <= 2'b00;
			n += int'(jmp === 1'b1 || bwr === 1'b1 || cst === 1'b1);
		end
		chk(n, 0);
	endtask
	// enter stop, wake by one pin, count the cycles the clocks stay off
	task automatic nap(input logic [7:0] c, input logic px);
		@(posedge clk) {bnd, stp, condition_code_register} <= {2'b11, c};
		for (k = 0; k < 40 && cst !== 1'b1; k++)
			@(posedge clk) {bnd, stp} <= 2'b00;
		tmo(k);
		{nonmaskable_request_pin_n, irq_n} <= {!px, px};
		for (n = 0; n < 40 && cst !== 1'b0; n++)
			@(posedge clk);
		tmo(n);
		{nonmaskable_request_pin_n, irq_n} <= 2'b11;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		void'($urandom(64248));
		{rst, por, irq_n, nonmaskable_request_pin_n} = 4'hf;
		{psel, pen, pwr, bnd, software_trap_instruction, wait_instruction, stp, rti, tap, ill} = '0;
		{paddr, pwd, ev, condition_code_register} = '0;
		{a, b, ix} = $urandom;
		{iy, npc} = $urandom;
		opa = 16'($urandom);
		sp = {8'h01, 8'($urandom)};
		repeat (12) @(posedge clk);
		{rst, por} <= 2'b00;
		n = 0;
		repeat (STAB + 20) begin
			@(posedge clk);
			n += int'(hold === 1'b1);
		end
		chk(n >= STAB && hold === 1'b0, 1);
		apb(0, iep_pkg::ADDR_CTRL, 0);
		chk(rd & 32'hf1, 32'h61);
		apb(0, 8'h40, 0);
		chk(rd, 0);
		exc(3'b100, 8'h40, iep_pkg::VEC_SWI, 8'h50, npc);
		exc(3'b010, 8'h00, iep_pkg::VEC_ILL, 8'h10, opa);
		{irq_n, nonmaskable_request_pin_n} <= 2'b00;
		exc(3'b000, 8'h00, iep_pkg::VEC_NONMASKABLE_REQUEST_PIN, 8'h50, npc);
		nonmaskable_request_pin_n <= 1'b1;
		exc(3'b000, 8'h00, 16'hffe2, 8'h10, npc);
		quiet(8'h10, 0);
		irq_n <= 1'b1;
		apb(1, iep_pkg::ADDR_CTRL, 32'h21);
		@(posedge clk) {tap, condition_code_register} <= 9'h100;
		@(posedge clk) tap <= 1'b0;
		apb(1, iep_pkg::ADDR_CTRL, 32'h91);
		apb(0, iep_pkg::ADDR_CTRL, 0);
		chk(rd & 32'hf1, 32'h21);
		apb(1, iep_pkg::ADDR_ENABLE, 32'h224);
		@(posedge clk) ev <= 16'h0224;
		@(posedge clk) ev <= 16'h0000;
		apb(0, iep_pkg::ADDR_SRC, 0);
		chk(rd, 32'h224);
		quiet(8'h10, 0);
		exc(3'b000, 8'h00, 16'hffda, 8'h10, npc);
		apb(1, iep_pkg::ADDR_CLEAR, 32'h4);
		exc(3'b000, 8'h00, 16'hffe8, 8'h10, npc);
		apb(1, iep_pkg::ADDR_CLEAR, 32'h200);
		exc(3'b000, 8'h00, 16'hffe0, 8'h10, npc);
		apb(1, iep_pkg::ADDR_CLEAR, 32'h20);
		quiet(8'h00, 0);
		sp <= sp - 16'h9;
		@(posedge clk) {bnd, rti} <= 2'b11;
		n = 0;
		for (k = 0; k < 40 && jmp !== 1'b1; k++) begin
			@(posedge clk) {bnd, rti} <= 2'b00;
			n += int'(brd === 1'b1);
		end
		tmo(k);
		chk({n[3:0], occr, jpc}, {4'h9, 8'h00, npc});
		apb(1, iep_pkg::ADDR_CTRL, 32'h23);
		exc(3'b001, 8'h10, 16'h0, 8'h0, npc);
		repeat (2) @(posedge clk);
		chk({baddr, tst}, {sp - 16'h8, 1'b1});
		nonmaskable_request_pin_n <= 1'b0;
		n = 0;
		for (k = 0; k < 40 && jmp !== 1'b1; k++) begin
			@(posedge clk);
			n += int'(bwr === 1'b1);
		end
		tmo(k);
		nonmaskable_request_pin_n <= 1'b1;
		chk({n[3:0], jpc}, {4'h0, iep_pkg::VEC_NONMASKABLE_REQUEST_PIN});
		quiet(8'h80, 1);
		nap(8'h50, 1);
		chk(n >= STAB, 1);
		quiet(8'h40, 0);
		apb(1, iep_pkg::ADDR_CTRL, 32'h22);
		nap(8'h00, 0);
		chk(n < STAB, 1);
		@(posedge clk) rst <= 1'b1;
		@(posedge clk) rst <= 1'b0;
		n = 0;
		repeat (10) begin
			@(posedge clk);
			n += int'(hold === 1'b1);
		end
		apb(0, iep_pkg::ADDR_CTRL, 0);
		chk({n[3:0], rd[7:0] & 8'hf1}, {4'h0, 8'h61});
		stop_test();
	end
endmodule // interrupt_entry_and_low_power_tb_top
